// *** verilog/mcpwm_pkg.sv ***
// Register map, field positions and reset values of the multi-channel PWM timer
package mcpwm_pkg;
  localparam int unsigned MCPWM_NMATCH = 7;
  localparam int unsigned MCPWM_NOUT   = 6;
  localparam int unsigned MCPWM_NCAP   = 2;
  // Word offsets (byte address)
  localparam logic [7:0] MCPWM_CTRL_OFS = 8'h00;
  localparam logic [7:0] MCPWM_TC_OFS   = 8'h04;
  localparam logic [7:0] MCPWM_PR_OFS   = 8'h08;
  localparam logic [7:0] MCPWM_PC_OFS   = 8'h0C;
  localparam logic [7:0] MCPWM_MCR_OFS  = 8'h10;
  localparam logic [7:0] MCPWM_PCR_OFS  = 8'h14;
  localparam logic [7:0] MCPWM_LER_OFS  = 8'h18;
  localparam logic [7:0] MCPWM_CCR_OFS  = 8'h1C;
  localparam logic [7:0] MCPWM_IR_OFS   = 8'h20;
  localparam logic [7:0] MCPWM_MR_OFS   = 8'h24;
  localparam logic [7:0] MCPWM_CR_OFS   = 8'h40;
  // Control register fields
  localparam int unsigned MCPWM_CTRL_EN    = 0;
  localparam int unsigned MCPWM_CTRL_RST   = 1;
  localparam int unsigned MCPWM_CTRL_PWMEN = 2;
  localparam int unsigned MCPWM_CTRL_MODE  = 3;
  localparam int unsigned MCPWM_CTRL_CSEL  = 5;
  // Match control: three bits per match register
  localparam int unsigned MCPWM_MCR_INT  = 0;
  localparam int unsigned MCPWM_MCR_RST  = 1;
  localparam int unsigned MCPWM_MCR_STOP = 2;
  // Output control: double-edge select low byte, output enable second byte
  localparam int unsigned MCPWM_PCR_DBL = 0;
  localparam int unsigned MCPWM_PCR_OEN = 8;
  // Capture control: three bits per capture input
  localparam int unsigned MCPWM_CCR_RISE = 0;
  localparam int unsigned MCPWM_CCR_FALL = 1;
  localparam int unsigned MCPWM_CCR_INT  = 2;
  // Status: match flags from bit 0, capture flags from bit 8
  localparam int unsigned MCPWM_IR_CAP = 8;
  localparam logic [31:0] MCPWM_RST_VAL = 32'h0000_0000;
  typedef enum logic [1:0] {
    MCPWM_MODE_TIMER = 2'b00,
    MCPWM_MODE_RISE  = 2'b01,
    MCPWM_MODE_FALL  = 2'b10,
    MCPWM_MODE_BOTH  = 2'b11
  } mcpwm_mode_t;
endpackage

// *** verilog/mcpwm_top.sv ***
// Multi-channel PWM timer with Wishbone register access
// Operation
// RULE_01 - Seven matches drive six PWM outputs
// RULE_02 - Match zero resets count, starts cycle
// RULE_03 - Single edge one match, double two
// RULE_04 - Single-edge outputs rise at cycle start
// RULE_05 - Double-edge: two matches place both edges
// RULE_06 - Period and width in whole counter ticks
// RULE_07 - Old match values used until released
// RULE_08 - Per match continue, stop, reset, flag
// RULE_09 - Count peripheral clock or capture input
// RULE_10 - Plain 32-bit timer with prescaler
// RULE_11 - Capture copies count on input edge
// RULE_12 - Released values load at cycle start
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
module mcpwm_top
  import mcpwm_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [7:0]            i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [31:0]           i_wb_dat,
  output logic      [31:0]           o_wb_dat,
  output logic                       o_wb_ack,
  input  wire logic [MCPWM_NCAP-1:0] i_cap,
  output logic      [MCPWM_NOUT-1:0] o_pwm,
  output logic                       o_irq
);
  // Counter narrower than two bits cannot hold a cycle
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie in 2..32");
  end

  logic [31:0]           ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0]      tc_r, tc_nxt;
  logic [CNT_W-1:0]      pr_r, pr_nxt;
  logic [CNT_W-1:0]      pc_r, pc_nxt;
  logic [20:0]           mcr_r, mcr_nxt;
  logic [15:0]           pcr_r, pcr_nxt;
  logic [6:0]            ler_r, ler_nxt;
  logic [5:0]            ccr_r, ccr_nxt;
  logic [9:0]            ir_r, ir_nxt;
  logic [CNT_W-1:0]      mr_sh_r  [MCPWM_NMATCH];
  logic [CNT_W-1:0]      mr_sh_nxt[MCPWM_NMATCH];
  logic [CNT_W-1:0]      mr_act_r [MCPWM_NMATCH];
  logic [CNT_W-1:0]      mr_act_nxt[MCPWM_NMATCH];
  logic [CNT_W-1:0]      cr_r  [MCPWM_NCAP];
  logic [CNT_W-1:0]      cr_nxt[MCPWM_NCAP];
  logic [MCPWM_NOUT-1:0] pwm_r, pwm_nxt;
  logic [31:0]           rdat_r, rdat_nxt;
  logic                  ack_r, ack_nxt;
  logic                  irq_r, irq_nxt;
  logic [MCPWM_NCAP-1:0] cap_s1_r, cap_s2_r, cap_s3_r;

  logic                  wr_en;
  logic [31:0]           wmask;
  logic [MCPWM_NCAP-1:0] cap_rise, cap_fall;
  logic                  tick_src, tick, any_rst, any_stop, cycle_start, pwm_en;
  logic [MCPWM_NMATCH-1:0] hit;
  mcpwm_mode_t           mode;

  assign wr_en = i_wb_cyc & i_wb_stb & i_wb_we & ~ack_r;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  // Edges judged on the second and third stages, never the first
  assign cap_rise = cap_s2_r & ~cap_s3_r;
  assign cap_fall = ~cap_s2_r & cap_s3_r;
  assign mode     = mcpwm_mode_t'(ctrl_r[MCPWM_CTRL_MODE +: 2]);
  assign pwm_en   = ctrl_r[MCPWM_CTRL_PWMEN];

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  // Tick source and match detection
  always_comb begin
    logic e;
    e = cap_rise[ctrl_r[MCPWM_CTRL_CSEL]];
    // RULE_09 clock source select
    unique case (mode)
      MCPWM_MODE_TIMER: tick_src = 1'b1;
      MCPWM_MODE_RISE:  tick_src = e;
      MCPWM_MODE_FALL:  tick_src = cap_fall[ctrl_r[MCPWM_CTRL_CSEL]];
      MCPWM_MODE_BOTH:  tick_src = e | cap_fall[ctrl_r[MCPWM_CTRL_CSEL]];
    endcase
    tick_src = tick_src & ctrl_r[MCPWM_CTRL_EN] & ~ctrl_r[MCPWM_CTRL_RST];
    // RULE_10 prescaler divides increments
    tick     = tick_src & (pc_r == pr_r);
    any_rst  = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < MCPWM_NMATCH; i++) begin
      hit[i]   = tick & (tc_r == mr_act_r[i]);
      // RULE_08 per-match reset and stop
      any_rst  = any_rst | (hit[i] & mcr_r[3*i + MCPWM_MCR_RST]);
      any_stop = any_stop | (hit[i] & mcr_r[3*i + MCPWM_MCR_STOP]);
    end
    // RULE_02 match zero always ends a PWM cycle
    any_rst     = any_rst | (hit[0] & pwm_en);
    cycle_start = hit[0] & (pwm_en | mcr_r[MCPWM_MCR_RST]);
  end

  // Register file, counter and outputs
  always_comb begin
    ctrl_nxt = ctrl_r;
    pr_nxt   = pr_r;
    mcr_nxt  = mcr_r;
    pcr_nxt  = pcr_r;
    ler_nxt  = ler_r;
    ccr_nxt  = ccr_r;
    ir_nxt   = ir_r;
    mr_sh_nxt  = mr_sh_r;
    mr_act_nxt = mr_act_r;
    cr_nxt   = cr_r;
    pwm_nxt  = pwm_r;
    // RULE_10 prescale and count
    if (ctrl_r[MCPWM_CTRL_RST]) begin
      pc_nxt = '0;
      tc_nxt = '0;
    end else begin
      pc_nxt = tick_src ? (tick ? '0 : pc_r + 1'b1) : pc_r;
      // RULE_06 period counts whole ticks
      tc_nxt = tick ? (any_rst ? '0 : tc_r + 1'b1) : tc_r;
    end
    // RULE_08 stop clears the enable
    if (any_stop) begin
      ctrl_nxt[MCPWM_CTRL_EN] = 1'b0;
    end
    // RULE_12 released shadows load at cycle start
    for (int i = 0; i < MCPWM_NMATCH; i++) begin
      if (!pwm_en) begin
        mr_act_nxt[i] = mr_sh_r[i];
      end else if (cycle_start && ler_r[i]) begin
        mr_act_nxt[i] = mr_sh_r[i];
        ler_nxt[i]    = 1'b0;
      end
    end
    // RULE_11 capture snapshot
    for (int c = 0; c < MCPWM_NCAP; c++) begin
      if ((cap_rise[c] && ccr_r[3*c + MCPWM_CCR_RISE]) ||
          (cap_fall[c] && ccr_r[3*c + MCPWM_CCR_FALL])) begin
        cr_nxt[c] = tc_r;
      end
    end
    // RULE_01 six outputs from seven matches
    for (int k = 1; k <= MCPWM_NOUT; k++) begin
      logic set;
      // RULE_03 single edge uses one match, double two
      // RULE_05 double edge: match k-1 rises, match k falls
      set = (pcr_r[MCPWM_PCR_DBL + k] && k > 1) ? hit[k-1] : cycle_start;
      // RULE_04 rise at cycle start; fall wins for constant low
      if (!pwm_en || !pcr_r[MCPWM_PCR_OEN + k - 1]) begin
        pwm_nxt[k-1] = 1'b0;
      end else if (hit[k]) begin
        pwm_nxt[k-1] = 1'b0;
      end else if (set) begin
        pwm_nxt[k-1] = 1'b1;
      end
    end
    // Bus writes; a hardware set beats a software clear
    if (wr_en) begin
      unique case (i_wb_adr)
        MCPWM_CTRL_OFS: ctrl_nxt = merge(ctrl_r, wmask, i_wb_dat) & 32'h0000_003F;
        MCPWM_PR_OFS:   pr_nxt = CNT_W'(merge(32'(pr_r), wmask, i_wb_dat));
        MCPWM_MCR_OFS:  mcr_nxt = 21'(merge(32'(mcr_r), wmask, i_wb_dat));
        MCPWM_PCR_OFS:  pcr_nxt = 16'(merge(32'(pcr_r), wmask, i_wb_dat));
        // RULE_07 software releases new values
        MCPWM_LER_OFS:  ler_nxt = 7'(merge(32'(ler_r), wmask, i_wb_dat));
        MCPWM_CCR_OFS:  ccr_nxt = 6'(merge(32'(ccr_r), wmask, i_wb_dat));
        MCPWM_IR_OFS:   ir_nxt = ir_r & ~10'(i_wb_dat & wmask);
        default: begin
          for (int i = 0; i < MCPWM_NMATCH; i++) begin
            if (i_wb_adr == MCPWM_MR_OFS + 8'(4*i)) begin
              mr_sh_nxt[i] = CNT_W'(merge(32'(mr_sh_r[i]), wmask, i_wb_dat));
            end
          end
        end
      endcase
    end
    // RULE_08 sticky match flags, applied after a clear
    for (int i = 0; i < MCPWM_NMATCH; i++) begin
      if (hit[i] && mcr_r[3*i + MCPWM_MCR_INT]) begin
        ir_nxt[i] = 1'b1;
      end
    end
    for (int c = 0; c < MCPWM_NCAP; c++) begin
      if (((cap_rise[c] && ccr_r[3*c + MCPWM_CCR_RISE]) ||
           (cap_fall[c] && ccr_r[3*c + MCPWM_CCR_FALL])) && ccr_r[3*c + MCPWM_CCR_INT]) begin
        ir_nxt[MCPWM_IR_CAP + c] = 1'b1;
      end
    end
    irq_nxt = |ir_nxt;
  end

  // Bus read path: one wait-free answer a cycle after the request
  always_comb begin
    ack_nxt  = i_wb_cyc & i_wb_stb & ~ack_r;
    rdat_nxt = '0;
    if (ack_nxt && !i_wb_we) begin
      unique case (i_wb_adr)
        MCPWM_CTRL_OFS: rdat_nxt = ctrl_r;
        MCPWM_TC_OFS:   rdat_nxt = 32'(tc_r);
        MCPWM_PR_OFS:   rdat_nxt = 32'(pr_r);
        MCPWM_PC_OFS:   rdat_nxt = 32'(pc_r);
        MCPWM_MCR_OFS:  rdat_nxt = 32'(mcr_r);
        MCPWM_PCR_OFS:  rdat_nxt = 32'(pcr_r);
        MCPWM_LER_OFS:  rdat_nxt = 32'(ler_r);
        MCPWM_CCR_OFS:  rdat_nxt = 32'(ccr_r);
        MCPWM_IR_OFS:   rdat_nxt = 32'(ir_r);
        default: begin
          for (int i = 0; i < MCPWM_NMATCH; i++) begin
            if (i_wb_adr == MCPWM_MR_OFS + 8'(4*i)) begin
              rdat_nxt = 32'(mr_sh_r[i]);
            end
          end
          for (int c = 0; c < MCPWM_NCAP; c++) begin
            if (i_wb_adr == MCPWM_CR_OFS + 8'(4*c)) begin
              rdat_nxt = 32'(cr_r[c]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r   <= MCPWM_RST_VAL;
      tc_r     <= '0;
      pr_r     <= '0;
      pc_r     <= '0;
      mcr_r    <= '0;
      pcr_r    <= '0;
      ler_r    <= '0;
      ccr_r    <= '0;
      ir_r     <= '0;
      pwm_r    <= '0;
      rdat_r   <= '0;
      ack_r    <= 1'b0;
      irq_r    <= 1'b0;
      cap_s1_r <= '0;
      cap_s2_r <= '0;
      cap_s3_r <= '0;
      for (int i = 0; i < MCPWM_NMATCH; i++) begin
        mr_sh_r[i]  <= '0;
        mr_act_r[i] <= '0;
      end
      for (int c = 0; c < MCPWM_NCAP; c++) begin
        cr_r[c] <= '0;
      end
    end else begin
      ctrl_r   <= ctrl_nxt;
      tc_r     <= tc_nxt;
      pr_r     <= pr_nxt;
      pc_r     <= pc_nxt;
      mcr_r    <= mcr_nxt;
      pcr_r    <= pcr_nxt;
      ler_r    <= ler_nxt;
      ccr_r    <= ccr_nxt;
      ir_r     <= ir_nxt;
      pwm_r    <= pwm_nxt;
      rdat_r   <= rdat_nxt;
      ack_r    <= ack_nxt;
      irq_r    <= irq_nxt;
      cap_s1_r <= i_cap;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      mr_sh_r  <= mr_sh_nxt;
      mr_act_r <= mr_act_nxt;
      cr_r     <= cr_nxt;
    end
  end

  assign o_wb_dat = rdat_r;
  assign o_wb_ack = ack_r;
  assign o_pwm    = pwm_r;
  assign o_irq    = irq_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  chk_cycle_reset: assert property (hit[0] && pwm_en |=> tc_r == '0) // RULE_02
    else $error("count not reset at end of cycle");
  chk_single_rise: assert property (cycle_start && pwm_en && pcr_r[MCPWM_PCR_OEN] && !hit[1]
      && !wr_en |=> o_pwm[0]) // RULE_04
    else $error("single-edge output did not rise at cycle start");
  chk_single_fall: assert property (hit[2] |=> !o_pwm[1]) // RULE_03
    else $error("output did not fall on its match");
  chk_dbl_rise: assert property (pwm_en && pcr_r[MCPWM_PCR_DBL + 2]
      && pcr_r[MCPWM_PCR_OEN + 1] && hit[1] && !hit[2] && !wr_en |=> o_pwm[1]) // RULE_05
    else $error("double-edge output did not rise");
  chk_shadow_hold: assert property (pwm_en && !cycle_start |=> $stable(mr_act_r[1])) // RULE_07
    else $error("active match changed mid-cycle");
  chk_shadow_load: assert property (pwm_en && cycle_start && ler_r[1]
      && !(wr_en && i_wb_adr == MCPWM_LER_OFS)
      |=> mr_act_r[1] == $past(mr_sh_r[1]) && !ler_r[1]) // RULE_12
    else $error("released value not loaded at cycle start");
  chk_match_stop: assert property (hit[0] && mcr_r[MCPWM_MCR_STOP] && !wr_en
      |=> !ctrl_r[MCPWM_CTRL_EN] ##1 $stable(tc_r)) // RULE_08
    else $error("stop on match did not halt counter");
  chk_match_flag: assert property (hit[3] && mcr_r[9 + MCPWM_MCR_INT] |=> ir_r[3] && o_irq) // RULE_08
    else $error("match flag not raised");
  chk_capture: assert property (cap_rise[0] && ccr_r[MCPWM_CCR_RISE] |=> cr_r[0] == $past(tc_r))
    // RULE_11
    else $error("capture did not snapshot the count");
  chk_prescale: assert property (!tick && !ctrl_r[MCPWM_CTRL_RST] |=> $stable(tc_r)) // RULE_10
    else $error("count moved without a prescaled tick");
endmodule

// *** dv/mcpwm_load_model.sv ***
// Load model on the PWM pins: counts high samples of each output
`timescale 1ns/100ps
module mcpwm_load_model
  import mcpwm_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_clr,
  input  wire logic [MCPWM_NOUT-1:0] i_pwm,
  output logic      [15:0]           o_hi [MCPWM_NOUT]
);
  // Counting high samples over whole periods makes the result phase independent
  always @(posedge i_ref_clk) begin
    for (int k = 0; k < MCPWM_NOUT; k++) begin
      o_hi[k] <= i_clr ? 16'h0000 : o_hi[k] + 16'(i_pwm[k]);
    end
  end
endmodule

// *** dv/mcpwm_top_tb.sv ***
// Self-checking bench for the multi-channel PWM timer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module mcpwm_top_tb
  import mcpwm_pkg::*;
;
  logic                  i_ref_clk, i_resetn, cyc, stb, we, ack, irq, clr;
  logic [7:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           dat, rdat, q, seed, mr [7];
  logic [1:0]            cap;
  logic [MCPWM_NOUT-1:0] pwm;
  logic [15:0]           hi [MCPWM_NOUT];
  int                    err_total, total_checks, cyc_cnt, n, nv;

  mcpwm_top i_mcpwm_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_cap(cap), .o_pwm(pwm), .o_irq(irq));
  mcpwm_load_model i_mcpwm_load_model (.i_ref_clk(i_ref_clk), .i_clr(clr), .i_pwm(pwm),
    .o_hi(hi));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // High samples of output k+1 over two periods
  function automatic int exp_hi(int k, logic dbl);
    int p;
    p = int'(mr[0]) + 1;
    if (dbl && k == 1) begin
      if (mr[1] < mr[2]) return 2 * int'(mr[2] - mr[1]);
      return 2 * (p - int'(mr[1] - mr[2]));
    end
    return 2 * (int'(mr[k + 1]) + 1);
  endfunction

  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge i_ref_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb_xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic measure(input logic dbl);
    @(posedge i_ref_clk);
    clr <= 1'b1;
    @(posedge i_ref_clk);
    clr <= 1'b0;
    repeat (2 * (int'(mr[0]) + 1)) @(posedge i_ref_clk);
    #1;
    for (int k = 0; k < MCPWM_NOUT; k++) begin
      if (dbl && k == 1) `CHK("dbl_hi", 16'(exp_hi(k, dbl)), hi[k])
      else `CHK("sgl_hi", 16'(exp_hi(k, dbl)), hi[k])
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Ceiling well above the fewer than one thousand cycles the sequence needs
  always @(posedge i_ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    {i_resetn, cyc, stb, we, clr} = 5'h00;
    {adr, sel, dat, cap} = '0;
    seed = 32'hD2F4;
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(MCPWM_TC_OFS);
    `CHK("tc_rst", 32'h0000_0000, q)
    rd(8'h80);
    `CHK("unmapped", 32'h0000_0000, q)
    for (int r = 0; r < 3; r++) begin
      wr(MCPWM_CTRL_OFS, 32'h0000_0002);
      mr[0] = 32'd8 + (rnd() % 32'd16);
      for (int k = 1; k < 7; k++) mr[k] = rnd() % mr[0];
      if (r == 0) {mr[1], mr[2]} = {32'h0, mr[0] - 32'd1};
      if (mr[1] == mr[2]) mr[2] = (mr[1] + 32'd1) % mr[0];
      for (int k = 0; k < 7; k++) wr(MCPWM_MR_OFS + 8'(4 * k), mr[k]);
      wr(MCPWM_PR_OFS, 32'h0000_0000);
      wr(MCPWM_PCR_OFS, 32'h0000_3F00 | (r == 1 ? 32'h4 : 32'h0));
      wr(MCPWM_CTRL_OFS, 32'h0000_0005);
      repeat (2 * (int'(mr[0]) + 1)) @(posedge i_ref_clk);
      measure(r == 1);
    end
    // New match value waits for release; two periods after the release it is in use
    nv = int'((mr[1] + 32'd3) % mr[0]);
    wr(MCPWM_MR_OFS + 8'h04, 32'(nv));
    measure(1'b0);
    `CHK("held", 16'(exp_hi(0, 1'b0)), hi[0])
    wr(MCPWM_LER_OFS, 32'h0000_0002);
    mr[1] = 32'(nv);
    repeat (2 * (int'(mr[0]) + 1)) @(posedge i_ref_clk);
    measure(1'b0);
    `CHK("released", 16'(exp_hi(0, 1'b0)), hi[0])
    rd(MCPWM_LER_OFS);
    `CHK("ler_clr", 32'h0000_0000, q)
    n = int'(mr[0]);
    wr(MCPWM_CTRL_OFS, 32'h0000_0002);
    wr(MCPWM_PCR_OFS, 32'h0000_0000);
    wr(MCPWM_MCR_OFS, 32'h0000_0005);
    wr(MCPWM_PR_OFS, 32'h0000_0003);
    wr(MCPWM_CTRL_OFS, 32'h0000_0001);
    repeat (2 * n) @(posedge i_ref_clk);
    rd(MCPWM_TC_OFS);
    `CHK("prescaled", 1'b1, q < 32'(n))
    repeat (4 * n + 8) @(posedge i_ref_clk);
    rd(MCPWM_TC_OFS);
    // The matching tick still advances the count once
    `CHK("stop_tc", 32'(n + 1), q)
    rd(MCPWM_CTRL_OFS);
    `CHK("stop_en", 32'h0000_0000, q)
    `CHK("irq_set", 1'b1, irq)
    wr(MCPWM_CCR_OFS, 32'h0000_0005);
    @(posedge i_ref_clk);
    cap <= 2'b01;
    repeat (8) @(posedge i_ref_clk);
    rd(MCPWM_CR_OFS);
    `CHK("cap_val", 32'(n + 1), q)
    rd(MCPWM_IR_OFS);
    `CHK("cap_flag", 32'h0000_0101, q & 32'h0000_0101)
    wr(MCPWM_IR_OFS, 32'h0000_03FF);
    rd(MCPWM_IR_OFS);
    `CHK("ir_clr", 32'h0000_0000, q)
    `CHK("irq_clr", 1'b0, irq)
    // Counter mode: rising edges of the first capture input drive the count
    wr(MCPWM_CTRL_OFS, 32'h0000_0002);
    wr(MCPWM_MCR_OFS, 32'h0000_0000);
    wr(MCPWM_PR_OFS, 32'h0000_0000);
    wr(MCPWM_CTRL_OFS, 32'h0000_0009);
    repeat (5) begin
      @(posedge i_ref_clk);
      cap <= 2'b00;
      repeat (5) @(posedge i_ref_clk);
      cap <= 2'b01;
      repeat (5) @(posedge i_ref_clk);
    end
    rd(MCPWM_TC_OFS);
    `CHK("cnt_mode", 32'h0000_0005, q)
    // Both edges of the second capture input drive the count
    wr(MCPWM_CTRL_OFS, 32'h0000_0002);
    wr(MCPWM_CTRL_OFS, 32'h0000_0039);
    repeat (3) begin
      @(posedge i_ref_clk);
      cap <= cap ^ 2'b10;
      repeat (6) @(posedge i_ref_clk);
    end
    rd(MCPWM_TC_OFS);
    `CHK("both_edges", 32'h0000_0003, q)
    stop_test();
  end
endmodule
